//--- hdl/bit_clock_gen.sv
// bit clock divider driving the bit clock line
`timescale 1ns/1ps
module bit_clock_gen #(
    parameter int HALF_CYC = modem_host_pkg::HALF_BIT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_line,
    output logic o_rise,
    output logic o_fall
);
    if (HALF_CYC < 2 || HALF_CYC > 65535)
    begin : g_chk
        $error("bit_clock_gen: HALF_CYC out of range");
    end
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic line_ff;
    logic wrap;
    // half period end and edge strobes
    assign wrap = i_run && (cnt_ff == 16'(HALF_CYC - 1));
    assign o_rise = wrap && !line_ff;
    assign o_fall = wrap && line_ff;
    assign nxt_cnt = (!i_run || wrap) ? 16'h0 : cnt_ff + 16'h1;
    assign o_line = line_ff;
    // counter and line, low while stopped
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_ff <= 16'h0;
            line_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            line_ff <= i_run && (line_ff ^ wrap);
        end
    end
endmodule : bit_clock_gen

//--- hdl/modem_host_pkg.sv
// constants and types for the modem host serial interface
package modem_host_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int CLK_NS = 25;
    // mode settle time in nanoseconds
    localparam int TCC_NS = 500000;
    localparam int TCC_CYCLES = (TCC_NS + CLK_NS - 1) / CLK_NS;
    localparam int BAUD = 4800;
    localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * BAUD);
    localparam int CREG_W = 48;
    localparam int EXT_BIT = 21;
    localparam int LONG_RD_BIT = 18;
    localparam int SYNC_BIT = 14;
    localparam logic [47:0] CREG_RESET = 48'h0;
    localparam logic [6:0] LEN_SHORT = 7'h18;
    localparam logic [6:0] LEN_LONG = 7'h30;
    localparam logic [6:0] CNT_SAT = 7'h7f;
    typedef enum logic [1:0]
    {
        MODE_TX = 2'b00,
        MODE_RX = 2'b01,
        MODE_WR = 2'b10,
        MODE_RD = 2'b11
    } mode_type;
    typedef struct packed
    {
        logic reg_data;
        logic rx_tx_select;
        logic uart_spi;
        logic txd;
    } host_pins_type;
    localparam host_pins_type PINS_RESET = '0;
endpackage : modem_host_pkg

//--- hdl/modem_host_serial_interface.sv
// host serial interface: mode decode, data path, control register
`timescale 1ns/1ps
module modem_host_serial_interface #(
    parameter int TCC_CYC = modem_host_pkg::TCC_CYCLES,
    parameter int HALF_CYC = modem_host_pkg::HALF_BIT_CYCLES,
    parameter logic [47:0] CREG_INIT = modem_host_pkg::CREG_RESET
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reg_data,
    input wire logic i_rx_tx_select,
    input wire logic i_uart_spi,
    input wire logic i_txd,
    input wire logic i_demod_bit,
    input wire logic i_tone_present,
    input wire logic i_cond_idle,
    output logic o_rxd,
    output logic o_bit_clock_line,
    output logic o_tx_power_on,
    output logic o_mod_enable,
    output logic o_mod_bit,
    output logic o_band_in_use_sens,
    output logic o_iface_mismatch,
    output logic [47:0] o_ctrl_reg
);
    if (TCC_CYC < 1 || TCC_CYC >= 2 ** 24)
    begin : g_chk
        $error("settle count out of range");
    end

    // pin synchronisers
    modem_host_pkg::host_pins_type pins_raw;
    modem_host_pkg::host_pins_type meta_ff;
    modem_host_pkg::host_pins_type pins_ff;
    logic reg_prev_ff;

    // mode and settle state
    modem_host_pkg::mode_type mode;
    modem_host_pkg::mode_type mode_ff;
    logic mode_change;
    logic [23:0] settle_ff;
    logic [23:0] nxt_settle;
    logic settled;
    logic sync_acc;
    logic idle_lvl;
    logic idle_hold;

    // bit clock
    logic clk_run;
    logic bc_rise;
    logic bc_fall;

    // control register and shift paths
    logic [47:0] creg_ff;
    logic [47:0] nxt_creg;
    logic [47:0] wr_sh_ff;
    logic [6:0] wr_cnt_ff;
    logic [6:0] nxt_wr_cnt;
    logic ext_mode;
    logic wr_commit;
    logic wr_full;
    logic wr_low;
    logic wr_abort;
    logic [47:0] rd_sh_ff;
    logic [47:0] nxt_rd_sh;
    logic [6:0] rd_cnt_ff;
    logic [6:0] rd_len;
    logic rd_entry;

    // data path
    logic rx_bit_ff;
    logic rxd_ff;
    logic nxt_rxd;
    logic rx_quiet;
    logic mod_bit_ff;
    logic sens_ff;
    logic tx_pwr_ff;

    assign pins_raw = '{
        reg_data: i_reg_data,
        rx_tx_select: i_rx_tx_select,
        uart_spi: i_uart_spi,
        txd: i_txd
    };

    // two flops on every host pin
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_ff <= modem_host_pkg::PINS_RESET;
            pins_ff <= modem_host_pkg::PINS_RESET;
            reg_prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pins_raw;
            pins_ff <= meta_ff;
            reg_prev_ff <= pins_ff.reg_data;
        end
    end

    // mode straight from select levels
    assign mode = modem_host_pkg::mode_type'(
        {pins_ff.reg_data, pins_ff.rx_tx_select});
    assign mode_change = (mode != mode_ff);
    assign sync_acc = creg_ff[modem_host_pkg::SYNC_BIT];
    assign idle_lvl = pins_ff.uart_spi;
    // uart with sync or spi with async is a bad pairing
    assign o_iface_mismatch = (pins_ff.uart_spi == sync_acc);

    // settle timer restarts on every mode change
    assign settled = (settle_ff == 24'(TCC_CYC));
    assign nxt_settle = mode_change ? 24'h0 :
        (settled ? settle_ff : settle_ff + 24'h1);
    assign idle_hold = (mode == modem_host_pkg::MODE_RX) && !settled;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_ff <= modem_host_pkg::MODE_TX;
            settle_ff <= 24'h0;
        end
        else
        begin
            mode_ff <= mode;
            settle_ff <= nxt_settle;
        end
    end

    // clock runs in register and settled sync modes, restarts low per mode
    assign clk_run = !mode_change && (mode[1]
        || (sync_acc && settled));

    bit_clock_gen #(
        .HALF_CYC(HALF_CYC)
    ) u_bit_clock (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(clk_run),
        .o_line(o_bit_clock_line),
        .o_rise(bc_rise),
        .o_fall(bc_fall)
    );

    // write shift counter, saturating so long writes stay long
    assign nxt_wr_cnt = (mode_ff != modem_host_pkg::MODE_WR) ? 7'h0 :
        ((wr_cnt_ff == modem_host_pkg::CNT_SAT) ? wr_cnt_ff :
        wr_cnt_ff + 7'h1);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_sh_ff <= 48'h0;
            wr_cnt_ff <= 7'h0;
        end
        else if (mode != modem_host_pkg::MODE_WR)
        begin
            wr_cnt_ff <= 7'h0;
        end
        else if (bc_rise)
        begin
            wr_sh_ff <= {wr_sh_ff[46:0], pins_ff.txd};
            wr_cnt_ff <= nxt_wr_cnt;
        end
    end

    // commit decision at the register select fall
    assign ext_mode = creg_ff[modem_host_pkg::EXT_BIT];
    assign wr_commit = reg_prev_ff && !pins_ff.reg_data
        && (mode_ff == modem_host_pkg::MODE_WR);
    assign wr_full = ext_mode
        && (wr_cnt_ff == modem_host_pkg::LEN_LONG);
    assign wr_low = ext_mode ?
        (wr_cnt_ff == modem_host_pkg::LEN_SHORT) :
        (wr_cnt_ff >= modem_host_pkg::LEN_SHORT);
    assign wr_abort = wr_commit && !wr_full && !wr_low;
    // short write touches only the low 24 bits
    assign nxt_creg = !wr_commit ? creg_ff :
        (wr_full ? wr_sh_ff :
        (wr_low ? {creg_ff[47:24], wr_sh_ff[23:0]} :
        creg_ff));

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            creg_ff <= CREG_INIT;
        end
        else
        begin
            creg_ff <= nxt_creg;
        end
    end
    assign o_ctrl_reg = creg_ff;

    // read length and loading of the read shifter
    assign rd_len = (ext_mode && creg_ff[modem_host_pkg::LONG_RD_BIT]) ?
        modem_host_pkg::LEN_LONG : modem_host_pkg::LEN_SHORT;
    assign rd_entry = (mode == modem_host_pkg::MODE_RD) && mode_change;
    assign nxt_rd_sh = rd_entry ?
        ((rd_len == modem_host_pkg::LEN_LONG) ? creg_ff :
        {creg_ff[23:0], 24'h0}) :
        ((bc_fall && rd_cnt_ff != 7'h0) ?
        {rd_sh_ff[46:0], 1'b0} : rd_sh_ff);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_sh_ff <= 48'h0;
            rd_cnt_ff <= 7'h0;
        end
        else
        begin
            rd_sh_ff <= nxt_rd_sh;
            if (rd_entry)
            begin
                rd_cnt_ff <= 7'h0;
            end
            else if ((bc_rise && rd_cnt_ff < rd_len)
                || (bc_fall && rd_cnt_ff == rd_len)) // one past last bit
            begin
                rd_cnt_ff <= rd_cnt_ff + 7'h1;
            end
        end
    end

    // receive data selection
    assign rx_quiet = !settled || !i_tone_present
        || i_cond_idle;
    always_comb
    begin
        nxt_rxd = idle_lvl;
        unique case (mode)
            modem_host_pkg::MODE_RX:
            begin
                if (!rx_quiet)
                begin
                    nxt_rxd = sync_acc ? rx_bit_ff :
                        i_demod_bit;
                end
            end
            modem_host_pkg::MODE_RD:
            begin
                if (rd_cnt_ff < rd_len ||
                    (rd_cnt_ff == rd_len && !bc_fall))
                begin
                    nxt_rxd = nxt_rd_sh[47];
                end
            end
            modem_host_pkg::MODE_TX, modem_host_pkg::MODE_WR:
                nxt_rxd = idle_lvl;
        endcase
    end

    // demod bit taken on falling bit clock, stable at rising
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_bit_ff <= 1'b0;
        end
        else if (bc_fall)
        begin
            rx_bit_ff <= i_demod_bit;
        end
    end

    // transmit power, modulator bit and sensitivity
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rxd_ff <= 1'b0;
            tx_pwr_ff <= 1'b0;
            mod_bit_ff <= 1'b0;
            sens_ff <= 1'b0;
        end
        else
        begin
            rxd_ff <= nxt_rxd;
            tx_pwr_ff <= (mode == modem_host_pkg::MODE_TX);
            sens_ff <= (mode == modem_host_pkg::MODE_RX)
                && pins_ff.txd;
            if (!sync_acc || bc_rise)
            begin
                mod_bit_ff <= pins_ff.txd;
            end
        end
    end

    assign o_rxd = rxd_ff;
    assign o_tx_power_on = tx_pwr_ff;
    assign o_mod_enable = tx_pwr_ff && settled && !mode_change;
    assign o_mod_bit = mod_bit_ff;
    assign o_band_in_use_sens = sens_ff;

    // checks
    property p_rx_power_off;
        @(posedge i_clk) disable iff (i_rst)
        (mode == modem_host_pkg::MODE_RX) |=> !o_tx_power_on;
    endproperty
    a_rx_power_off: assert property (p_rx_power_off)
        else $error("transmit powered during reception");
    property p_idle_level;
        @(posedge i_clk) disable iff (i_rst)
        (mode == modem_host_pkg::MODE_RX) && !i_tone_present
        |=> o_rxd == $past(pins_ff.uart_spi);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("receive idle level wrong");
    property p_rx_clock_low;
        @(posedge i_clk) disable iff (i_rst)
        idle_hold && $past(idle_hold) |-> !o_bit_clock_line;
    endproperty
    a_rx_clock_low: assert property (p_rx_clock_low)
        else $error("bit clock high while settling");
    property p_commit_only_on_fall;
        @(posedge i_clk) disable iff (i_rst)
        $changed(o_ctrl_reg) |-> $past(wr_commit);
    endproperty
    a_commit_only_on_fall: assert property (p_commit_only_on_fall)
        else $error("register changed outside commit");
    property p_short_dropped;
        @(posedge i_clk) disable iff (i_rst)
        wr_commit && !ext_mode && wr_cnt_ff < 7'h18
        |=> $stable(o_ctrl_reg);
    endproperty
    a_short_dropped: assert property (p_short_dropped)
        else $error("short write not discarded");

    property p_ext_low_only;
        @(posedge i_clk) disable iff (i_rst)
        wr_commit && ext_mode && wr_cnt_ff == 7'h18
        |=> $stable(o_ctrl_reg[47:24])
        && o_ctrl_reg[23:0] == $past(wr_sh_ff[23:0]);
    endproperty
    a_ext_low_only: assert property (p_ext_low_only)
        else $error("24-bit extended write wrong");

    property p_abort_keeps;
        @(posedge i_clk) disable iff (i_rst)
        wr_abort |=> $stable(o_ctrl_reg) ##1 $stable(o_ctrl_reg);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps)
        else $error("aborted write changed register");

    property p_tx_sample;
        @(posedge i_clk) disable iff (i_rst)
        sync_acc && bc_rise && mode == modem_host_pkg::MODE_TX
        |=> o_mod_bit == $past(pins_ff.txd);
    endproperty
    a_tx_sample: assert property (p_tx_sample)
        else $error("transmit bit not sampled at rise");

    property p_band_in_use;
        @(posedge i_clk) disable iff (i_rst)
        (mode == modem_host_pkg::MODE_RX) && pins_ff.txd
        |=> o_band_in_use_sens;
    endproperty
    a_band_in_use: assert property (p_band_in_use)
        else $error("band in use threshold not chosen");
endmodule : modem_host_serial_interface

//--- testbench/host_model.sv
// host controller model: mode pins, register shifting on the bit clock
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk,
    input wire logic i_bit_clock_line,
    input wire logic i_rxd,
    output modem_host_pkg::host_pins_type o_pins
);
    // pins start at reset levels until a task drives them
    initial o_pins = modem_host_pkg::PINS_RESET;

    // drive all host pins just after a clock edge
    task automatic set_pins(input modem_host_pkg::host_pins_type p);
        o_pins = p;
    endtask : set_pins

    // bounded wait for the bit clock line to move to lvl
    task automatic wait_line(input logic lvl, output bit ok);
        bit armed;
        armed = 0;
        ok = 0;
        for (int n = 0; n < 400 && !ok; n++)
        begin
            @(posedge i_clk);
            #1;
            if (i_bit_clock_line !== lvl)
                armed = 1;
            else if (armed)
                ok = 1;
        end
    endtask : wait_line

    // n register bits msb first; txd moves only after a falling edge
    task automatic shift(input logic rd, input int n, input logic [47:0] wd,
        output logic [47:0] rv, output bit ok);
        bit k;
        rv = '0;
        ok = 1;
        o_pins = {1'b1, rd, o_pins.uart_spi, wd[n-1]};
        // let the select pass the synchroniser and the clock restart
        for (int w = 0; w < 3; w++)
        begin
            @(posedge i_clk);
            #1;
        end
        for (int i = n - 1; i >= 0; i--)
        begin
            wait_line(1'b1, k);
            ok &= k;
            rv = {rv[46:0], i_rxd};
            wait_line(1'b0, k);
            ok &= k;
            if (i > 0)
                o_pins.txd = wd[i-1];
        end
        // back to reception; released txd shows the inverse level
        o_pins = {1'b0, 1'b1, o_pins.uart_spi, ~o_pins.txd};
    endtask : shift
endmodule : host_model

//--- testbench/tb.sv
// self-checking bench for the modem host serial interface
`timescale 1ns/1ps
module tb;
    logic i_clk;
    logic i_rst;
    logic demod;
    logic tone;
    logic cidle;
    logic rxd;
    logic bcl;
    logic txp;
    logic moden;
    logic modbit;
    logic biu;
    logic mism;
    logic hi;
    logic [47:0] creg;
    logic [47:0] r;
    modem_host_pkg::host_pins_type pins;
    int miscompares;
    int checked;

    // host partner on the pins and the bit clock line
    host_model host (.i_clk(i_clk), .i_bit_clock_line(bcl), .i_rxd(rxd),
        .o_pins(pins));

    // short settle and bit periods keep the run brief
    modem_host_serial_interface #(.TCC_CYC(20), .HALF_CYC(4)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_data(pins.reg_data),
        .i_rx_tx_select(pins.rx_tx_select), .i_uart_spi(pins.uart_spi),
        .i_txd(pins.txd), .i_demod_bit(demod), .i_tone_present(tone),
        .i_cond_idle(cidle), .o_rxd(rxd), .o_bit_clock_line(bcl),
        .o_tx_power_on(txp), .o_mod_enable(moden), .o_mod_bit(modbit),
        .o_band_in_use_sens(biu), .o_iface_mismatch(mism),
        .o_ctrl_reg(creg));

    // 40 mhz clock
    initial
    begin
        i_clk = 0;
        forever #12.5 i_clk = ~i_clk;
    end

    // compare and count
    task automatic check(input string what, input logic [47:0] seen,
        input logic [47:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // counts, verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // a wait that ran out ends the run
    task automatic need(input bit ok);
        if (!ok)
        begin
            miscompares++;
            final_report();
        end
    endtask : need

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            #1;
        end
    endtask : tick

    // pins as {reg_data, rx_tx_select, uart_spi, txd}
    task automatic mode(input logic [3:0] p);
        host.set_pins(p);
    endtask : mode

    task automatic edge_wait(input logic lvl);
        bit ok;
        host.wait_line(lvl, ok);
        need(ok);
    endtask : edge_wait

    task automatic wreg(input int n, input logic [47:0] d);
        bit ok;
        host.shift(1'b0, n, d, r, ok);
        need(ok);
        tick(6);
    endtask : wreg

    task automatic rreg(input int n);
        bit ok;
        host.shift(1'b1, n, '0, r, ok);
        need(ok);
        tick(2);
    endtask : rreg

    // one synchronous transmit bit, changed after a falling edge
    task automatic txbit(input logic b);
        edge_wait(1'b0);
        mode({3'b000, b});
        edge_wait(1'b1);
        tick(1);
        check("mod_bit sync", modbit, b);
    endtask : txbit

    // main sequence
    initial
    begin
        miscompares = 0;
        checked = 0;
        i_rst = 1;
        demod = 0;
        tone = 0;
        cidle = 0;
        tick(20);
        i_rst = 0;
        check("ctrl_reg", creg, 48'h0);
        check("tx_power", txp, 1'b0);
        check("mismatch", mism, 1'b1);
        $display("test reset done");
        tick(4);
        wreg(24, 48'h05c3a5);
        check("wr24", creg, 48'h05c3a5);
        wreg(20, 48'h0fffff);
        check("wr20", creg, 48'h05c3a5);
        wreg(28, 48'h905c3a7);
        check("wr28", creg, 48'h05c3a7);
        rreg(24);
        check("rd24", r, 48'h05c3a7);
        $display("test normal register done");
        wreg(24, 48'h2c4000);
        rreg(48);
        check("rd48", r, 48'h2c4000);
        wreg(30, 48'h3fffffff);
        check("wr30", creg, 48'h2c4000);
        wreg(48, 48'h5a5a5a2c4000);
        check("wr48", creg, 48'h5a5a5a2c4000);
        wreg(24, 48'h284000);
        check("wr24x", creg, 48'h5a5a5a284000);
        rreg(48);
        check("rd short", r, 48'h284000000000);
        $display("test extended register done");
        mode(4'b0001);
        tick(3);
        check("tx power", txp, 1'b1);
        check("mod early", moden, 1'b0);
        tick(21);
        check("mod settled", moden, 1'b1);
        txbit(1'b1);
        txbit(1'b0);
        txbit(1'b1);
        $display("test sync transmit done");
        mode(4'b0100);
        tick(3);
        check("rx power", txp, 1'b0);
        hi = 0;
        repeat (18)
        begin
            tick(1);
            hi = hi | bcl;
        end
        check("clock held", hi, 1'b0);
        check("rx idle", rxd, 1'b0);
        tick(5);
        tone = 1;
        for (int v = 1; v >= 0; v--)
        begin
            demod = v[0];
            edge_wait(1'b0);
            edge_wait(1'b1);
            check("rxd sync", rxd, v[0]);
        end
        demod = 1;
        cidle = 1;
        tick(3);
        check("cond idle", rxd, 1'b0);
        cidle = 0;
        mode(4'b0101);
        tick(4);
        check("band in use", biu, 1'b1);
        mode(4'b0100);
        tick(4);
        check("band normal", biu, 1'b0);
        $display("test sync receive done");
        mode(4'b0100);
        tick(3);
        wreg(24, 48'h280000);
        check("async cfg", creg, 48'h5a5a5a280000);
        demod = 0;
        mode(4'b0110);
        tick(5);
        check("async settle", rxd, 1'b1);
        tick(20);
        check("uart async", mism, 1'b0);
        for (int v = 0; v < 2; v++)
        begin
            demod = v[0];
            tick(2);
            check("rxd async", rxd, v[0]);
        end
        tone = 0;
        tick(2);
        check("no tone", rxd, 1'b1);
        mode(4'b0011);
        tick(25);
        check("async mod en", moden, 1'b1);
        check("async bit1", modbit, 1'b1);
        mode(4'b0010);
        tick(4);
        check("async bit0", modbit, 1'b0);
        mode(4'b0000);
        tick(4);
        check("spi async", mism, 1'b1);
        $display("test async done");
        final_report();
    end
endmodule : tb
